// ### core/general_digital_io_port.v
// What this block does
// - Direction, drive and input bit per pin
// - Direction one drives, zero makes input
// - Input pull-up when drive set, not disabled
// - Pull-up off when drive zero or output
// - Global disable removes all pull-ups
// - Output level follows the drive bit
// - Reset tri-states all pins asynchronously
// - Pad level always readable in input bit
// - Falling-edge latch then rising-edge input bit
// - Written level reaches the pins on the same edge as the register
// - Strobes per port, clock and disable shared
`timescale 1ns/10ps
`include "gpio_port_regs.vh"

module general_digital_io_port (
    input  wire        clk,
    input  wire        rstn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [15:0] pad_in,
    output reg  [15:0] pad_out,
    output reg  [15:0] pad_oe_n,
    output reg  [15:0] pullup_en
);

    // Geometry of the pin vectors
    localparam integer NPINS  = `GPIO_PIN_COUNT;
    localparam integer NPORTS = `GPIO_NUM_PORTS;
    localparam integer PW     = `GPIO_PORT_WIDTH;

    // Decode: bit 3 hit, bit 2 port index, bits 1:0 register kind
    function [3:0] reg_code;
        input [7:0] addr;
        begin
            if (addr == `GPIO_SPECIAL_OFS) begin
                reg_code = {1'b1, 1'b0, `GPIO_KIND_SPECIAL};
            end else if (addr == `GPIO_DRIVE_OFS) begin
                reg_code = {1'b1, 1'b0, `GPIO_KIND_DRIVE};
            end else if (addr == `GPIO_DIR_OFS) begin
                reg_code = {1'b1, 1'b0, `GPIO_KIND_DIR};
            end else if (addr == `GPIO_INPUT_OFS) begin
                reg_code = {1'b1, 1'b0, `GPIO_KIND_INPUT};
            end else if (addr == (`GPIO_PORT_STRIDE + `GPIO_DRIVE_OFS)) begin
                reg_code = {1'b1, 1'b1, `GPIO_KIND_DRIVE};
            end else if (addr == (`GPIO_PORT_STRIDE + `GPIO_DIR_OFS)) begin
                reg_code = {1'b1, 1'b1, `GPIO_KIND_DIR};
            end else if (addr == (`GPIO_PORT_STRIDE + `GPIO_INPUT_OFS)) begin
                reg_code = {1'b1, 1'b1, `GPIO_KIND_INPUT};
            end else begin
                reg_code = 4'h0;
            end
        end
    endfunction

    reg  [15:0] dir_q;
    reg  [15:0] dir_d;
    reg  [15:0] drive_q;
    reg  [15:0] drive_d;
    reg         pud_q;
    reg         pud_d;
    wire [15:0] input_q;
    reg  [31:0] rd_data;
    wire [3:0]  code;
    wire        access;
    wire        commit_wr;

    assign code      = reg_code(paddr);
    assign access    = psel & penable;
    assign commit_wr = access & pready & pwrite & code[3] & pstrb[0];

    // Fields of the decoded register code
    wire        hit;
    wire        port_sel;
    wire [1:0]  kind;

    assign hit      = code[3];
    assign port_sel = code[2];
    assign kind     = code[1:0];

    // First access cycle; ready is raised from here
    wire        first_access;

    assign first_access = access & ~pready; // Wait state cycle

    // Port bytes offered to the read mux
    wire [7:0]  drive_byte;
    wire [7:0]  dir_byte;
    wire [7:0]  input_byte;

    // Upper byte belongs to port one, lower byte to port zero
    assign drive_byte = port_sel ? drive_q[15:8] : drive_q[7:0];
    assign dir_byte   = port_sel ? dir_q[15:8] : dir_q[7:0];
    assign input_byte = port_sel ? input_q[15:8] : input_q[7:0];

    // Ready: one wait state, then a one-cycle pulse
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
        end else begin
            pready <= first_access;
        end
    end

    // Error flag rides with ready on an unmapped address
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pslverr <= 1'b0;
        end else if (first_access) begin
            pslverr <= ~hit;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // Read data stands only in the ready cycle, zero otherwise
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= `GPIO_ZERO32;
        end else if (first_access && !pwrite) begin
            prdata <= rd_data;
        end else begin
            prdata <= `GPIO_ZERO32;
        end
    end

    // Read mux; input register shows synchronised pad at all times
    always @* begin
        rd_data = `GPIO_ZERO32;
        if (!hit) begin
            // Unmapped: data stays zero, error is flagged elsewhere
            rd_data = `GPIO_ZERO32;
        end else if (kind == `GPIO_KIND_DRIVE) begin
            rd_data[`GPIO_DATA_MSB:`GPIO_DATA_LSB] = drive_byte;
        end else if (kind == `GPIO_KIND_DIR) begin
            rd_data[`GPIO_DATA_MSB:`GPIO_DATA_LSB] = dir_byte;
        end else if (kind == `GPIO_KIND_INPUT) begin
            rd_data[`GPIO_DATA_MSB:`GPIO_DATA_LSB] = input_byte;
        end else begin
            rd_data[`GPIO_PUD_BIT] = pud_q;
        end
    end

    // Shared pull-up disable, one bit for every port
    always @* begin
        pud_d = pud_q;
        if (commit_wr && kind == `GPIO_KIND_SPECIAL) begin
            pud_d = pwdata[`GPIO_PUD_BIT];
        end
    end

    // Committed write to one register kind of one port
    function kind_write;
        input         commit;
        input         sel;
        input [1:0]   got;
        input [1:0]   want;
        input integer port_no;
        begin
            kind_write = commit && (sel == port_no[0]) && (got == want);
        end
    endfunction

    // Per-port write strobes; each port owns one byte of the pin vectors
    genvar p;
    generate
        for (p = 0; p < `GPIO_NUM_PORTS; p = p + 1) begin : g_port
            wire wr_drive;
            wire wr_dir;

            // One strobe each for the drive and direction registers of this port, shared by its pins
            assign wr_drive = kind_write(commit_wr, port_sel, kind, `GPIO_KIND_DRIVE, p);
            assign wr_dir   = kind_write(commit_wr, port_sel, kind, `GPIO_KIND_DIR, p);

            // Next register state for this port's pins
            always @* begin
                drive_d[p*8 +: 8] = wr_drive ? pwdata[`GPIO_DATA_MSB:`GPIO_DATA_LSB] : drive_q[p*8 +: 8];
                dir_d[p*8 +: 8]   = wr_dir ? pwdata[`GPIO_DATA_MSB:`GPIO_DATA_LSB] : dir_q[p*8 +: 8];
            end
        end
    endgenerate

    // One-hot pin modes of the configuration table
    localparam [3:0] MODE_TRI  = 4'h1;
    localparam [3:0] MODE_PULL = 4'h2;
    localparam [3:0] MODE_LOW  = 4'h4;
    localparam [3:0] MODE_HIGH = 4'h8;

    // Pin mode from direction, drive and the shared disable
    function [3:0] pin_mode;
        input dir_bit;
        input drive_bit;
        input disable_all;
        begin
            if (dir_bit) begin
                if (drive_bit) begin
                    pin_mode = MODE_HIGH;
                end else begin
                    pin_mode = MODE_LOW;
                end
            end else if (drive_bit && !disable_all) begin
                pin_mode = MODE_PULL;
            end else begin
                pin_mode = MODE_TRI;
            end
        end
    endfunction

    // Next pin controls, one slice per pin
    wire [15:0] oe_n_d;
    wire [15:0] out_d;
    wire [15:0] pull_d;

    genvar n;
    generate
        for (n = 0; n < NPINS; n = n + 1) begin : g_pin
            wire [3:0] mode;

            // Decode this pin once, then fan out to the three controls
            assign mode = pin_mode(dir_d[n], drive_d[n], pud_d);

            // Output enable is active low while the pin drives
            assign oe_n_d[n] = ~((mode == MODE_LOW) | (mode == MODE_HIGH));

            // Driven level; low while the pin is an input
            assign out_d[n] = (mode == MODE_HIGH);

            // Pull-up only in the pull mode, never on an output
            assign pull_d[n] = (mode == MODE_PULL);
        end
    endgenerate

    // Control registers; all zero out of reset
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drive_q <= {2{`GPIO_DRIVE_RST}};
            dir_q   <= {2{`GPIO_DIR_RST}};
            pud_q   <= `GPIO_PUD_RST;
        end else begin
            drive_q <= drive_d;
            dir_q   <= dir_d;
            pud_q   <= pud_d;
        end
    end

    // Pin drivers move with the register write; reset tri-states every pin
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pad_oe_n  <= `GPIO_PINS_ONES;
            pad_out   <= `GPIO_PINS_ZERO;
            pullup_en <= `GPIO_PINS_ZERO;
        end else begin
            pad_oe_n  <= oe_n_d;
            pad_out   <= out_d;
            pullup_en <= pull_d;
        end
    end

    // Input synchroniser, one pair of stages per port
    genvar s;
    generate
        for (s = 0; s < NPORTS; s = s + 1) begin : g_sync
            reg [7:0] hold_q;
            reg [7:0] bits_q;

            // First stage: samples the pad at each falling edge of clk, holds until the next
            always @(negedge clk or negedge rstn) begin
                if (!rstn) begin
                    hold_q <= `GPIO_PORT_ZERO;
                end else begin
                    hold_q <= pad_in[s*PW +: PW];
                end
            end

            // Second stage: loads the held level at the next rising edge
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    bits_q <= `GPIO_PORT_ZERO;
                end else begin
                    bits_q <= hold_q;
                end
            end

            // Only the second stage feeds the readable input bits
            assign input_q[s*PW +: PW] = bits_q;
        end
    endgenerate

endmodule

// ### common/gpio_port_regs.vh
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

// Geometry: two ports of eight pins
`define GPIO_NUM_PORTS      2
`define GPIO_PORT_WIDTH     8
`define GPIO_PIN_COUNT      16
`define GPIO_ADDR_WIDTH     8

// Byte offsets inside one port block
`define GPIO_PORT_STRIDE    8'h10
`define GPIO_DRIVE_OFS      8'h00
`define GPIO_DIR_OFS        8'h04
`define GPIO_INPUT_OFS      8'h08
// Shared special function control register
`define GPIO_SPECIAL_OFS    8'h20

// Field positions
`define GPIO_PUD_BIT        0
`define GPIO_DATA_LSB       0
`define GPIO_DATA_MSB       7

// Register kinds returned by the decoder
`define GPIO_KIND_DRIVE     2'h0
`define GPIO_KIND_DIR       2'h1
`define GPIO_KIND_INPUT     2'h2
`define GPIO_KIND_SPECIAL   2'h3

// Reset values
`define GPIO_DRIVE_RST      8'h00
`define GPIO_DIR_RST        8'h00
`define GPIO_PUD_RST        1'h0
`define GPIO_ZERO32         32'h0000_0000

// Whole pin vector and single port constants
`define GPIO_PINS_ONES      16'hFFFF
`define GPIO_PINS_ZERO      16'h0000
`define GPIO_PORT_ZERO      8'h00

`endif

// ### verification/gpio_checker_assertions.sv
`timescale 1ns/10ps
module gpio_checker (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe_n,
    input wire logic [15:0] pullup_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Completed write and completed write with byte 0 enabled
    wire acc = psel && penable && pready && pwrite;
    wire wr  = acc && pstrb[0];
    a_pull_rule: assert property ((~pad_oe_n & pullup_en) == 16'h0000) else $error("pull-up on output");
    a_quiet_input: assert property ((pad_out & pad_oe_n) == 16'h0000) else $error("input drives level");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_wait: assert property ($rose(penable) && psel |=> pready) else $error("ready late");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_cfg_hold: assert property (!acc |=> $stable(pad_oe_n) && $stable(pullup_en)) else $error("pins moved");
    a_reset_tri: assert property ($rose(rstn) |-> &pad_oe_n && pullup_en == 16'h0000) else $error("not tri");
    a_dir_write: assert property (wr && paddr == 8'h04 |=> pad_oe_n[7:0] == ~$past(pwdata[7:0]))
        else $error("direction wrong");
    a_pud_all: assert property (wr && paddr == 8'h20 && pwdata[0] |=> pullup_en == 16'h0000)
        else $error("pull-up kept");
    c_err: cover property (pslverr);
    c_pull: cover property (pullup_en != 16'h0000);
    c_dir: cover property (wr && paddr == 8'h14);
endmodule

bind general_digital_io_port gpio_checker chk (.*);

// ### verification/pad_world.sv
`timescale 1ns/10ps
module pad_world (
    input wire logic        clk,
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe_n,
    input wire logic [15:0] pullup_en,
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_lvl,
    output logic     [15:0] pad_in
);
    logic [15:0] flt_q = 16'h5555;
    // Undriven pins with no pull-up wander every cycle
    always @(posedge clk) flt_q <= ~flt_q;
    // Pin driver first, then outside driver, then pull-up
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_lvl) | (pad_oe_n & ~ext_en & (pullup_en | flt_q));
endmodule

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, last_err;
    logic [7:0]  paddr = 0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] pwdata = 0, prdata, r;
    logic [15:0] pad_in, pad_out, pad_oe_n, pullup_en, ext_en = 0;
    int          bad_count = 0, num_checks = 0, cyc = 0;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    general_digital_io_port uut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe_n, .pullup_en);
    pad_world pad (.clk, .pad_out, .pad_oe_n, .pullup_en, .ext_en, .ext_lvl(16'h3c00), .pad_in);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        last_err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Drive then direction then control: whole-byte steps on port one only
    task automatic step(input logic [7:0] d, input logic [7:0] v, input logic p);
        logic ext;
        ext = d == 0 && (v == 0 || p);
        ext_en <= ext ? 16'hff00 : 16'h0000;
        apb(1, 8'h10, {24'h0, v}, r);
        apb(1, 8'h14, {24'h0, d}, r);
        apb(1, 8'h20, {31'h0, p}, r);
        repeat (2) @(posedge clk);
        chk(pad_oe_n, {~d, 8'hff});
        chk(pad_out, {d & v, 8'h00});
        chk(pullup_en, {~d & v & {8{~p}}, 8'h00});
        apb(0, 8'h18, 0, r);
        chk(r, d != 0 ? v : (ext ? 8'h3c : 8'hff));
    endtask
    task automatic t_reset;
        apb(0, 8'h04, 0, r);
        chk(r, 0);
        apb(1, 8'h04, 32'hff, r);
        @(posedge clk);
        rstn <= 0;
        @(posedge clk);
        chk(pad_oe_n, 16'hffff);
        chk(pullup_en, 16'h0000);
        rstn <= 1;
        apb(0, 8'h10, 0, r);
        chk(r, 0);
        $display("reset test done");
    endtask
    task automatic t_bad;
        apb(1, 8'h30, 32'hff, r);
        chk(last_err, 1);
        apb(1, 8'h18, 32'hff, r);
        chk(last_err, 0);
        pstrb <= 0;
        apb(1, 8'h04, 32'hff, r);
        pstrb <= 4'hf;
        apb(0, 8'h04, 0, r);
        chk(r, 0);
        $display("error test done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            stop_test;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1;
        t_reset;
        step(8'h00, 8'h00, 0);
        step(8'h00, 8'hff, 0);
        step(8'hff, 8'hff, 0);
        step(8'hff, 8'h00, 0);
        step(8'h00, 8'hff, 1);
        $display("mode test done");
        t_bad;
        stop_test;
    end
endmodule
